/* verilog/gps_regs.svh */
/*
 * Register selectors, field positions, reset values and pin maps of the
 * I/O port block with pin steering.
 * Assumes: included by the package and the design files by bare name.
 */
`ifndef GPS_REGS_SVH
`define GPS_REGS_SVH

// Sizes
`define GPS_PORT_W      8
`define GPS_NPORTS      3
`define GPS_NPINS       24
`define GPS_NFUNC       9
`define GPS_PORT_IDX_W  2
`define GPS_PIN_IDX_W   5

// Register selectors on the write port
`define GPS_SEL_DIR     3'h0
`define GPS_SEL_LEVEL   3'h1
`define GPS_SEL_LATCH   3'h2
`define GPS_SEL_ANALOG  3'h3
`define GPS_SEL_STEER   3'h4

// Steering control bit positions
`define GPS_STEER_RX    7
`define GPS_STEER_SDO   6
`define GPS_STEER_SS    5
`define GPS_STEER_SDA   4
`define GPS_STEER_TX    2
`define GPS_STEER_GRDB  1
`define GPS_STEER_GRDA  0
`define GPS_STEER_MASK  8'hf7

// Reset values
`define GPS_RST_DIR     24'hffffff
`define GPS_RST_LATCH   24'h000000
`define GPS_RST_ANALOG  24'h000000
`define GPS_RST_STEER   8'h00

// Function pin pairs: select bit clear picks the primary pin
`define GPS_RX_PRI      5'h0d
`define GPS_RX_ALT      5'h05
`define GPS_TX_PRI      5'h0e
`define GPS_TX_ALT      5'h04
`define GPS_SDO_PRI     5'h11
`define GPS_SDO_ALT     5'h01
`define GPS_SS_PRI      5'h12
`define GPS_SS_ALT      5'h03
`define GPS_SDA_PRI     5'h10
`define GPS_SDA_ALT     5'h02
`define GPS_G1A_PRI     5'h15
`define GPS_G1A_ALT     5'h06
`define GPS_G1B_PRI     5'h16
`define GPS_G1B_ALT     5'h07
`define GPS_G2A_PRI     5'h17
`define GPS_G2A_ALT     5'h08
`define GPS_G2B_PRI     5'h14
`define GPS_G2B_ALT     5'h09

`endif

/* verilog/gps_pkg.sv */
/*
 * Types of the I/O port block.
 * Assumes: gps_regs.svh on the include path.
 */
`include "gps_regs.svh"

package gps_pkg;

	// Whole register state of the port block
	typedef struct packed {
		logic [`GPS_NPINS-1:0] dir;
		logic [`GPS_NPINS-1:0] latch;
		logic [`GPS_NPINS-1:0] analog;
		logic [7:0]            steer;
		logic [`GPS_NPINS-1:0] level;
		logic [`GPS_NFUNC-1:0] fin;
	} gps_state_t;

endpackage

/* verilog/gps_pin_cell.sv */
/*
 * One pin's output driver choice between port latch and peripheral.
 * Assumes: override inputs already resolved by the steering logic.
 */
`timescale 1ns/1ns

module gps_pin_cell (
	input  wire logic dir_i,
	input  wire logic latch_i,
	input  wire logic ovr_en_i,
	input  wire logic ovr_out_i,
	input  wire logic ovr_oe_i,
	output logic      pin_o,
	output logic      pin_oe_o
);

	// Peripheral owns level and direction when it claims the pin
	always_comb begin
		if (ovr_en_i) begin
			pin_o    = ovr_out_i;
			pin_oe_o = ovr_oe_i;
		end else begin
			pin_o    = latch_i;
			pin_oe_o = ~dir_i;
		end
	end

endmodule // gps_pin_cell

/* verilog/gps_port.sv */
/*
 * Three 8-bit general purpose I/O ports with direction, output latch,
 * pin readback, analog input disable and peripheral pin steering.
 *
 * Pin numbering: port 0 owns pins 0-7, port 1 pins 8-15, port 2 pins 16-23.
 * Steerable functions, their steering bit and their pin pair
 * (select bit clear / select bit set):
 *   receive or sync data     bit 7   pin 13 / pin 5
 *   transmit or sync clock   bit 2   pin 14 / pin 4
 *   serial data out          bit 6   pin 17 / pin 1
 *   slave select             bit 5   pin 18 / pin 3
 *   i2c data                 bit 4   pin 16 / pin 2
 *   converter 1 guard A      bit 0   pin 21 / pin 6
 *   converter 1 guard B      bit 1   pin 22 / pin 7
 *   converter 2 guard A      bit 0   pin 23 / pin 8
 *   converter 2 guard B      bit 1   pin 20 / pin 9
 * One guard bit moves both converters' drives of that letter together.
 *
 * Timing:
 *   register readbacks show a write one cycle after its strobe;
 *   pin levels and peripheral inputs lag the pins by one cycle;
 *   pin drive and drive enable follow the peripheral inputs in the same
 *   cycle, because the output path holds no flop;
 *   a steering change moves the overrides one cycle after its write.
 *
 * Limitations:
 *   port index 3 is out of range and its direction, latch and analog writes are dropped;
 *   selector codes above the steering code are ignored;
 *   weak pull-ups are not modelled;
 *   two functions on one pin leave the lower function index in charge,
 *   though the present pin map shares no pin between functions.
 *
 * Assumes: pins and peripheral signals synchronous to clk_i; software
 * writes arrive as one-cycle strobes with a selector and a port index;
 * gps_regs.svh on the include path.
 */
`timescale 1ns/1ns

`include "gps_regs.svh"

module gps_port
	import gps_pkg::*;
(
	input  wire logic                        clk_i,
	input  wire logic                        reset_i,
	input  wire logic                        wr_i,
	input  wire logic [2:0]                  wr_sel_i,
	input  wire logic [`GPS_PORT_IDX_W-1:0]  wr_port_i,
	input  wire logic [`GPS_PORT_W-1:0]      wr_data_i,
	output logic      [`GPS_NPINS-1:0]       pin_direction_o,
	output logic      [`GPS_NPINS-1:0]       output_latch_o,
	output logic      [`GPS_NPINS-1:0]       pin_level_o,
	output logic      [`GPS_NPINS-1:0]       analog_select_o,
	output logic      [7:0]                  pin_steering_control_o,
	input  wire logic [`GPS_NFUNC-1:0]       periph_en_i,
	input  wire logic [`GPS_NFUNC-1:0]       periph_out_i,
	input  wire logic [`GPS_NFUNC-1:0]       periph_oe_i,
	output logic      [`GPS_NFUNC-1:0]       periph_in_o,
	input  wire logic [`GPS_NPINS-1:0]       pin_i,
	output logic      [`GPS_NPINS-1:0]       pin_o,
	output logic      [`GPS_NPINS-1:0]       pin_oe_o
);

	// Whole register state and its next value
	gps_state_t state_r;
	gps_state_t state_nxt;

	// Chosen pin per function, then per-pin override view
	logic [`GPS_PIN_IDX_W-1:0] fpin     [`GPS_NFUNC];
	logic [`GPS_NPINS-1:0]     ovr_en;
	logic [`GPS_NPINS-1:0]     ovr_out;
	logic [`GPS_NPINS-1:0]     ovr_oe;
	logic [`GPS_NPINS-1:0]     buf_in;

	// Steering: function order rx, tx, sdo, ss, sda, g1a, g1b, g2a, g2b
	always_comb begin
		fpin[0] = state_r.steer[`GPS_STEER_RX]   ? `GPS_RX_ALT  : `GPS_RX_PRI;
		fpin[1] = state_r.steer[`GPS_STEER_TX]   ? `GPS_TX_ALT  : `GPS_TX_PRI;
		fpin[2] = state_r.steer[`GPS_STEER_SDO]  ? `GPS_SDO_ALT : `GPS_SDO_PRI;
		fpin[3] = state_r.steer[`GPS_STEER_SS]   ? `GPS_SS_ALT  : `GPS_SS_PRI;
		fpin[4] = state_r.steer[`GPS_STEER_SDA]  ? `GPS_SDA_ALT : `GPS_SDA_PRI;
		fpin[5] = state_r.steer[`GPS_STEER_GRDA] ? `GPS_G1A_ALT : `GPS_G1A_PRI;
		fpin[6] = state_r.steer[`GPS_STEER_GRDB] ? `GPS_G1B_ALT : `GPS_G1B_PRI;
		fpin[7] = state_r.steer[`GPS_STEER_GRDA] ? `GPS_G2A_ALT : `GPS_G2A_PRI;
		fpin[8] = state_r.steer[`GPS_STEER_GRDB] ? `GPS_G2B_ALT : `GPS_G2B_PRI;
	end

	// Override reaches only the chosen pin; lower function index wins a clash
	always_comb begin
		ovr_en  = '0;
		ovr_out = '0;
		ovr_oe  = '0;
		for (int f = `GPS_NFUNC - 1; f >= 0; f--) begin
			if (periph_en_i[f]) begin
				ovr_en[fpin[f]]  = 1'b1;
				ovr_out[fpin[f]] = periph_out_i[f];
				ovr_oe[fpin[f]]  = periph_oe_i[f];
			end
		end
	end

	// Digital input buffer, gated off by analog select
	// Gated before both the readback and the peripheral inputs, so an
	// analog pin never feeds a mid-level into the digital logic
	assign buf_in = pin_i & ~state_r.analog;

	// Software writes and pin sampling
	always_comb begin
		state_nxt       = state_r;
		state_nxt.level = buf_in;
		for (int f = 0; f < `GPS_NFUNC; f++) begin
			state_nxt.fin[f] = buf_in[fpin[f]];
		end
		if (wr_i) begin
			case (wr_sel_i)
				`GPS_SEL_DIR: begin
					state_nxt.dir[wr_port_i*`GPS_PORT_W +: `GPS_PORT_W] = wr_data_i;
				end
				`GPS_SEL_LEVEL, `GPS_SEL_LATCH: begin
					state_nxt.latch[wr_port_i*`GPS_PORT_W +: `GPS_PORT_W] = wr_data_i;
				end
				`GPS_SEL_ANALOG: begin
					state_nxt.analog[wr_port_i*`GPS_PORT_W +: `GPS_PORT_W] = wr_data_i;
				end
				`GPS_SEL_STEER: begin
					// Direction bits untouched here on purpose
					state_nxt.steer = wr_data_i & `GPS_STEER_MASK;
				end
				default: begin
					state_nxt.steer = state_r.steer;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_r.dir    <= `GPS_RST_DIR;
			state_r.latch  <= `GPS_RST_LATCH;
			state_r.analog <= `GPS_RST_ANALOG;
			state_r.steer  <= `GPS_RST_STEER;
			state_r.level  <= '0;
			state_r.fin    <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Per-pin drivers
	// Output path left combinational: a peripheral's level reaches its pin
	// in the same cycle, at the cost of no glitch filtering here
	for (genvar p = 0; p < `GPS_NPINS; p++) begin : g_pin
		gps_pin_cell u_cell (
			.dir_i     (state_r.dir[p]),
			.latch_i   (state_r.latch[p]),
			.ovr_en_i  (ovr_en[p]),
			.ovr_out_i (ovr_out[p]),
			.ovr_oe_i  (ovr_oe[p]),
			.pin_o     (pin_o[p]),
			.pin_oe_o  (pin_oe_o[p])
		);
	end

	// Readback straight from flops
	assign pin_direction_o        = state_r.dir;
	assign output_latch_o         = state_r.latch;
	assign pin_level_o            = state_r.level;
	assign analog_select_o        = state_r.analog;
	assign pin_steering_control_o = state_r.steer;
	assign periph_in_o            = state_r.fin;

endmodule // gps_port

/* verif/gps_pin_model.sv */
/* Far-side pin model for the port block.
   Assumes the bench supplies the level of undriven pins. */
`timescale 1ns/1ns
module gps_pin_model (
	input  wire logic [23:0] drv_i,
	input  wire logic [23:0] oe_i,
	input  wire logic [23:0] ext_i,
	output logic      [23:0] pin_o
);
	// Released pins show the bench's fresh level, never the old drive
	assign pin_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule // gps_pin_model

/* verif/gps_port_monitor.sv */
/* Concurrent checks on the port block's ports.
   Assumes a bind from the bench top with ports matched by name. */
`timescale 1ns/1ns
module gps_port_monitor (
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic        wr_i,
	input wire logic [2:0]  wr_sel_i,
	input wire logic [1:0]  wr_port_i,
	input wire logic [7:0]  wr_data_i,
	input wire logic [23:0] pin_direction_o,
	input wire logic [23:0] output_latch_o,
	input wire logic [23:0] pin_level_o,
	input wire logic [23:0] analog_select_o,
	input wire logic [7:0]  pin_steering_control_o,
	input wire logic [8:0]  periph_en_i,
	input wire logic [8:0]  periph_out_i,
	input wire logic [8:0]  periph_oe_i,
	input wire logic [8:0]  periph_in_o,
	input wire logic [23:0] pin_i,
	input wire logic [23:0] pin_o,
	input wire logic [23:0] pin_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// Writes land in the addressed slice one cycle later
	dir_write_a: assert property (wr_i && wr_sel_i == 0 && wr_port_i < 3 |=>
		pin_direction_o[$past(wr_port_i)*8+:8] == $past(wr_data_i)) else $error("direction write lost");
	latch_write_a: assert property (wr_i && wr_sel_i inside {1, 2} && wr_port_i < 3 |=>
		output_latch_o[$past(wr_port_i)*8+:8] == $past(wr_data_i)) else $error("latch write lost");
	// Guarded after reset: the first sample still holds reset values
	level_read_a: assert property (!$past(reset_i) |->
		pin_level_o == $past(pin_i & ~analog_select_o)) else $error("pin level wrong");
	spare_bit_a: assert property (pin_steering_control_o[3] == 0) else $error("steer bit 3 set");
	rx_input_a: assert property (!$past(reset_i) |-> periph_in_o[0] ==
		$past(pin_steering_control_o[7] ? pin_i[5] & !analog_select_o[5] : pin_i[13] & !analog_select_o[13]))
		else $error("rx input pin wrong");
	steer_dir_a: assert property (wr_i && wr_sel_i == 4 |=> $stable(pin_direction_o))
		else $error("steering moved direction");
	plain_pin_a: assert property (pin_oe_o[0] == !pin_direction_o[0] &&
		(pin_direction_o[0] || pin_o[0] == output_latch_o[0])) else $error("plain pin drive wrong");
	rx_primary_a: assert property (periph_en_i[0] && !pin_steering_control_o[7] |->
		pin_o[13] == periph_out_i[0] && pin_oe_o[13] == periph_oe_i[0] && pin_oe_o[5] == !pin_direction_o[5])
		else $error("rx primary override wrong");
	rx_alt_a: assert property (periph_en_i[0] && pin_steering_control_o[7] |->
		pin_o[5] == periph_out_i[0] && pin_oe_o[5] == periph_oe_i[0] && pin_oe_o[13] == !pin_direction_o[13])
		else $error("rx alternate override wrong");
	cover property (periph_en_i[0] && pin_steering_control_o[7]);
	cover property (wr_i && wr_sel_i == 4);
	cover property (|(pin_i & analog_select_o));
endmodule // gps_port_monitor

/* verif/testbench.sv */
/* Self-checking bench for the port block with pin steering.
   Assumes design, pin model and checker compiled before it. */
`timescale 1ns/1ns
module testbench;
	logic        clk_i, reset_i, wr_i;
	logic [2:0]  wr_sel_i, w;
	logic [1:0]  wr_port_i;
	logic [7:0]  wr_data_i, steer, e_st;
	logic [23:0] dir, lat, lvl, ana, pin_i, pin_o, oe, ext, e_dir, e_lat, e_ana, d, q, s;
	logic [8:0]  en, pout, poe, fin, fi;
	logic [23:0] lv;
	int          pp[9] = '{13, 14, 17, 18, 16, 21, 22, 23, 20}; // Primary pin per function
	int          ap[9] = '{5, 4, 1, 3, 2, 6, 7, 8, 9};          // Alternate pin per function
	int          sb[9] = '{7, 2, 6, 5, 4, 0, 1, 0, 1};          // Steering bit per function
	int          pn;
	logic [31:0] seed = 32'hd0fa6140;
	logic [2:0]  wq[$];
	logic [23:0] vq[$];
	string       nm[8] = '{"dir", "periph_in", "latch", "analog", "steer", "level", "drive", "pin"};
	int          errors = 0, comparisons = 0, i;
	gps_port uut (.clk_i(clk_i), .reset_i(reset_i), .wr_i(wr_i), .wr_sel_i(wr_sel_i), .wr_port_i(wr_port_i),
		.wr_data_i(wr_data_i), .pin_direction_o(dir), .output_latch_o(lat), .pin_level_o(lvl),
		.analog_select_o(ana), .pin_steering_control_o(steer), .periph_en_i(en), .periph_out_i(pout),
		.periph_oe_i(poe), .periph_in_o(fin), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(oe));
	gps_pin_model far (.drv_i(pin_o), .oe_i(oe), .ext_i(ext), .pin_o(pin_i));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic note(input logic [2:0] k, input logic [23:0] v);
		wq.push_back(k);
		vq.push_back(v);
	endtask
	// Leaves the strobe up so writes can run back to back
	task automatic wr(input logic [2:0] sl, input logic [1:0] p, input logic [7:0] dt);
		wr_i = 1;
		wr_sel_i = sl;
		wr_port_i = p;
		wr_data_i = dt;
		@(negedge clk_i);
		case (sl)
			0: e_dir[p*8+:8] = dt;
			1, 2: e_lat[p*8+:8] = dt;
			3: e_ana[p*8+:8] = dt;
			4: e_st = dt & 8'hf7;
			default: ;
		endcase
		note(sl inside {3'h0, 3'h3, 3'h4} ? sl : 3'h2, sl == 0 ? e_dir : sl == 3 ? e_ana :
			sl == 4 ? {16'h0, e_st} : e_lat);
		if (sl == 4) note(0, e_dir);
	endtask
	task automatic cmp(input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s exp %h got %h", nm[w], exp, seen);
		end
	endtask
	task automatic results();
		if (errors == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		clk_i = 0;
		forever #2 clk_i = ~clk_i;
	end
	// Watcher: takes every queued note, oldest first, once outputs have settled
	always @(negedge clk_i) begin
		#1;
		while (wq.size() > 0) begin
			w = wq.pop_front();
			case (w)
				0: s = dir;
				1: s = {15'h0, fin};
				2: s = lat;
				3: s = ana;
				4: s = {16'h0, steer};
				5: s = lvl;
				6: s = oe;
				default: s = pin_o & oe;
			endcase
			cmp(s, vq.pop_front());
		end
	end
	initial begin
		#4000;
		errors++;
		results();
	end
	initial begin
		{reset_i, wr_i, wr_sel_i, wr_port_i, wr_data_i, en, pout, poe, ext} = {1'b1, 65'h0};
		{e_dir, e_lat, e_ana, e_st} = {24'hffffff, 56'h0};
		repeat (8) @(negedge clk_i);
		reset_i = 0;
		note(0, e_dir);
		note(4, 0);
		note(2, e_lat);
		note(3, e_ana);
		note(5, 0);
		note(1, 0);
		for (i = 0; i < 24; i++) wr(3'(i % 8), 2'(i / 5 % 3), 8'(rnd()));
		for (i = 0; i < 8; i++) wr(4, 0, 8'h1 << i);
		repeat (24) begin
			wr(4, 0, 8'(rnd()));
			wr(0, 2'(rnd() % 3), 8'(rnd()));
			wr(3, 2'(rnd() % 3), 8'(rnd()));
			wr(2, 2'(rnd() % 3), 8'(rnd()));
			wr_i = 0;
			ext = 24'(rnd());
			en = 9'(rnd());
			pout = 9'(rnd());
			poe = 9'(rnd());
			@(negedge clk_i);
			d = ~e_dir;
			q = e_lat;
			for (i = 0; i < 9; i++) begin
				pn = e_st[sb[i]] ? ap[i] : pp[i];
				if (en[i]) {d[pn], q[pn]} = {poe[i], pout[i]};
			end
			lv = ((d & q) | (~d & ext)) & ~e_ana;
			for (i = 0; i < 9; i++) fi[i] = lv[e_st[sb[i]] ? ap[i] : pp[i]];
			note(6, d);
			note(7, d & q);
			note(5, lv);
			note(1, {15'h0, fi});
		end
		@(negedge clk_i);
		results();
	end
endmodule // testbench
bind gps_port gps_port_monitor mon (.*);
